//--- verilog/exec_unit_regs.vh
// Register map, instruction fields and timing constants for exec_unit
`ifndef EXEC_UNIT_REGS_VH
`define EXEC_UNIT_REGS_VH

// Byte offsets of the register words
`define REG_INSTR 8'h00
`define REG_ACC 8'h04
`define REG_STATUS 8'h08
`define REG_TIMING 8'h0C
`define REG_PC 8'h10
`define REG_STACK 8'h14
`define REG_WATCHDOG 8'h18
`define REG_WAKE 8'h1C
`define FILE_BASE_BIT 7
`define FILE_IDX_HI 6
`define FILE_IDX_LO 2

// Instruction word fields
`define OPC_HI 11
`define OPC_LO 8
`define DEST_BIT 5
`define FADR_HI 4
`define FADR_LO 0
`define IMM_HI 7
`define IMM_LO 0

// Opcode values
`define OP_IDLE 4'h0
`define OP_OR_IMM 4'h1
`define OP_OR_FILE 4'h2
`define OP_STORE_ACC 4'h3
`define OP_COPY_FILE 4'h4
`define OP_LOAD_IMM 4'h5
`define OP_LOAD_TIMING 4'h6
`define OP_RETURN_IMM 4'h7
`define OP_SLEEP 4'h8

// Status word bit positions
`define ST_ZERO 0
`define ST_EXPIRY_N 1
`define ST_SLEEP_N 2
`define ST_PIN_WAKE 3
`define ST_HALTED 4
`define ST_BUSY 5
`define ST_ILLEGAL 6
`define WAKE_CMD_BIT 0
`define WD_PRE_LO 8

// Reset values
`define ACC_RST 8'h00
`define TIMING_RST 8'hFF
`define PC_RST 11'h000
`define WD_CLEAR 8'h00
`define PRE_CLEAR 8'h00
`define PRE_TOP 8'hFF

// Watchdog tick timing: last divider count, one tick every 100 clocks
`define WD_TICK_LAST 8'h63

`endif

//--- verilog/exec_unit.v
// Instruction execution unit for move, OR, return and sleep operations
//
// Overview of operation
// - or_immediate_op ORs accumulator with 8-bit immediate into accumulator, sets zero.
// - or_file_op ORs accumulator with file register 0..31 to destination, sets zero.
// - Destination bit 0 writes accumulator, 1 writes the addressed file register.
// - store_acc_op copies accumulator to file register, flags unchanged.
// - copy_file_op moves file register to destination, sets zero, even in place.
// - load_immediate_op loads 8-bit immediate into accumulator, flags unchanged.
// - Timing register load copies accumulator into timing configuration, no flags.
// - return_immediate_op loads immediate to accumulator, pc from stack_top.
// - return_immediate_op takes two instruction cycles.
// - Sleep clears watchdog_counter to 00h and its prescaler to 0.
// - Sleep sets expiry_status_flag, clears sleep_entered_flag, keeps pin_wake_flag.
// - After sleep the oscillator stops and the unit stays halted until the wake pin or a wake command.
`timescale 1ns/10ps
`include "exec_unit_regs.vh"

module exec_unit (
   // Clock and reset
   input wire clk,
   input wire rst,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Core pins
   input wire wake_pin,
   output wire osc_run,
   output wire [7:0] timing_cfg
);

   localparam ST_IDLE = 2'b00;
   localparam ST_EXEC = 2'b01;
   localparam ST_RET2 = 2'b10;
   localparam ST_SLEEP = 2'b11;
   localparam [7:0] TICK_LAST = `WD_TICK_LAST;

   // Bus phase state
   reg wr_pend_reg;
   reg rd_pend_reg;
   reg [7:0] adr_reg;
   // Core state
   reg [1:0] state_reg;
   reg [11:0] instr_reg;
   reg [7:0] acc_reg;
   reg zero_reg;
   reg expiry_n_reg;
   reg sleep_n_reg;
   reg pin_wake_reg;
   reg illegal_reg;
   reg [7:0] timing_reg;
   reg [10:0] pc_reg;
   reg [10:0] stack_top_reg;
   reg [7:0] wd_cnt_reg;
   reg [7:0] wd_pre_reg;
   reg [7:0] tick_reg;
   reg wake_s1_reg;
   reg wake_s2_reg;
   reg [7:0] file_mem [0:31];

   wire busy;
   wire wr_ok;
   wire issue;
   wire tick;
   wire [3:0] opc;
   wire dest_file;
   wire [4:0] fadr;
   wire [7:0] imm;
   wire [7:0] file_val;
   wire [4:0] bus_fidx;
   reg [7:0] result;
   reg res_to_dest;
   reg file_we;
   reg [4:0] file_wa;
   reg [7:0] file_wd;
   reg [31:0] rd_mux;

   // Instruction field split
   assign opc = instr_reg[`OPC_HI:`OPC_LO];
   assign dest_file = instr_reg[`DEST_BIT];
   assign fadr = instr_reg[`FADR_HI:`FADR_LO];
   assign imm = instr_reg[`IMM_HI:`IMM_LO];
   assign file_val = file_mem[fadr];
   assign bus_fidx = adr_reg[`FILE_IDX_HI:`FILE_IDX_LO];

   // Bus handshake; reads take one wait state
   assign hreadyout = ~rd_pend_reg;
   assign hresp = 1'b0;
   assign busy = (state_reg == ST_EXEC) | (state_reg == ST_RET2);
   // Writes during execution are dropped with an OKAY response,
   // so software polls the busy bit before its next access
   assign wr_ok = wr_pend_reg & ~busy;
   assign issue = wr_ok & (adr_reg == `REG_INSTR) & (state_reg == ST_IDLE);
   assign osc_run = (state_reg != ST_SLEEP);
   assign timing_cfg = timing_reg;
   assign tick = (tick_reg == TICK_LAST);

   // Address phase capture
   always @(posedge clk) begin
      if (rst) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         adr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         if (hsel & htrans[1] & hready) begin
            adr_reg <= haddr[7:0];
            wr_pend_reg <= hwrite;
            rd_pend_reg <= ~hwrite;
         end
      end
   end

   // Read data selection
   always @* begin
      rd_mux = 32'h0000_0000;
      // Upper half of the map is the file, one entry per word
      if (adr_reg[`FILE_BASE_BIT]) begin
         rd_mux[7:0] = file_mem[bus_fidx];
      end else begin
         case (adr_reg)
            `REG_INSTR: rd_mux[11:0] = instr_reg;
            `REG_ACC: rd_mux[7:0] = acc_reg;
            `REG_STATUS: begin
               rd_mux[`ST_ZERO] = zero_reg;
               rd_mux[`ST_EXPIRY_N] = expiry_n_reg;
               rd_mux[`ST_SLEEP_N] = sleep_n_reg;
               rd_mux[`ST_PIN_WAKE] = pin_wake_reg;
               rd_mux[`ST_HALTED] = (state_reg == ST_SLEEP);
               rd_mux[`ST_BUSY] = busy;
               rd_mux[`ST_ILLEGAL] = illegal_reg;
            end
            `REG_TIMING: rd_mux[7:0] = timing_reg;
            `REG_PC: rd_mux[10:0] = pc_reg;
            `REG_STACK: rd_mux[10:0] = stack_top_reg;
            `REG_WATCHDOG: begin
               rd_mux[7:0] = wd_cnt_reg;
               rd_mux[15:`WD_PRE_LO] = wd_pre_reg;
            end
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // Read data register, loaded in the wait cycle
   always @(posedge clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_pend_reg) begin
         hrdata <= rd_mux;
      end
   end

   // Operation result and its destination
   always @* begin
      result = 8'h00;
      res_to_dest = 1'b0;
      case (opc)
         `OP_OR_IMM: result = acc_reg | imm;
         `OP_OR_FILE: begin
            result = acc_reg | file_val;
            res_to_dest = 1'b1;
         end
         `OP_COPY_FILE: begin
            result = file_val;
            res_to_dest = 1'b1;
         end
         default: result = 8'h00;
      endcase
   end

   // File register write port, core or bus
   always @* begin
      file_we = 1'b0;
      file_wa = fadr;
      file_wd = acc_reg;
      if (state_reg == ST_EXEC) begin
         if (opc == `OP_STORE_ACC) begin
            file_we = 1'b1;
         end else if (res_to_dest & dest_file) begin
            file_we = 1'b1;
            file_wd = result;
         end
      end else if (wr_ok & adr_reg[`FILE_BASE_BIT]) begin
         file_we = 1'b1;
         file_wa = bus_fidx;
         file_wd = hwdata[7:0];
      end
   end

   // File register storage, one entry per address
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_file
         always @(posedge clk) begin
            if (rst) begin
               file_mem[gi] <= 8'h00;
            end else if (file_we & (file_wa == gi)) begin
               file_mem[gi] <= file_wd;
            end
         end
      end
   endgenerate

   // Wake pin synchroniser
   always @(posedge clk) begin
      if (rst) begin
         wake_s1_reg <= 1'b0;
         wake_s2_reg <= 1'b0;
      end else begin
         // Only the second stage is read by the sequencer
         wake_s1_reg <= wake_pin;
         wake_s2_reg <= wake_s1_reg;
      end
   end

   // Watchdog tick divider, prescaler and counter
   always @(posedge clk) begin
      if (rst) begin
         tick_reg <= 8'h00;
         wd_pre_reg <= `PRE_CLEAR;
         wd_cnt_reg <= `WD_CLEAR;
      end else begin
         tick_reg <= tick ? 8'h00 : tick_reg + 8'h01;
         if (state_reg == ST_EXEC && opc == `OP_SLEEP) begin
            // Divider restarts too, so no early tick follows sleep
            tick_reg <= 8'h00;
            wd_pre_reg <= `PRE_CLEAR;
            wd_cnt_reg <= `WD_CLEAR;
         end else if (tick) begin
            wd_pre_reg <= wd_pre_reg + 8'h01;
            if (wd_pre_reg == `PRE_TOP) begin
               wd_cnt_reg <= wd_cnt_reg + 8'h01;
            end
         end
      end
   end

   // Sequencer, accumulator, flags and control registers
   always @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         instr_reg <= 12'h000;
         acc_reg <= `ACC_RST;
         zero_reg <= 1'b0;
         expiry_n_reg <= 1'b1;
         sleep_n_reg <= 1'b1;
         pin_wake_reg <= 1'b0;
         illegal_reg <= 1'b0;
         timing_reg <= `TIMING_RST;
         pc_reg <= `PC_RST;
         stack_top_reg <= `PC_RST;
      end else begin
         // Software writes while the core is not executing
         if (wr_ok) begin
            case (adr_reg)
               `REG_ACC: acc_reg <= hwdata[7:0];
               `REG_STATUS: begin
                  zero_reg <= hwdata[`ST_ZERO];
                  expiry_n_reg <= hwdata[`ST_EXPIRY_N];
                  sleep_n_reg <= hwdata[`ST_SLEEP_N];
                  if (hwdata[`ST_PIN_WAKE]) begin
                     pin_wake_reg <= 1'b0;
                  end
                  if (hwdata[`ST_ILLEGAL]) begin
                     illegal_reg <= 1'b0;
                  end
               end
               `REG_PC: pc_reg <= hwdata[10:0];
               `REG_STACK: stack_top_reg <= hwdata[10:0];
               default: pc_reg <= pc_reg;
            endcase
         end
         case (state_reg)
            ST_IDLE: begin
               if (issue) begin
                  instr_reg <= hwdata[11:0];
                  state_reg <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               state_reg <= ST_IDLE;
               pc_reg <= pc_reg + 11'h001;
               case (opc)
                  `OP_IDLE: pc_reg <= pc_reg + 11'h001;
                  `OP_OR_IMM: begin
                     acc_reg <= result;
                     zero_reg <= (result == 8'h00);
                  end
                  `OP_OR_FILE, `OP_COPY_FILE: begin
                     if (!dest_file) begin
                        acc_reg <= result;
                     end
                     zero_reg <= (result == 8'h00);
                  end
                  `OP_STORE_ACC: pc_reg <= pc_reg + 11'h001;
                  `OP_LOAD_IMM: acc_reg <= imm;
                  `OP_LOAD_TIMING: timing_reg <= acc_reg;
                  `OP_RETURN_IMM: begin
                     acc_reg <= imm;
                     state_reg <= ST_RET2;
                  end
                  `OP_SLEEP: begin
                     expiry_n_reg <= 1'b1;
                     sleep_n_reg <= 1'b0;
                     state_reg <= ST_SLEEP;
                  end
                  // Unknown codes flag illegal and still step pc
                  default: illegal_reg <= 1'b1;
               endcase
            end
            ST_RET2: begin
               // Second cycle: return address from stack_top
               pc_reg <= stack_top_reg;
               state_reg <= ST_IDLE;
            end
            ST_SLEEP: begin
               // Halted until the wake pin or a wake command
               // Placed after the write decode so the wake set wins
               // over a same-cycle clear of pin_wake
               if (wake_s2_reg) begin
                  pin_wake_reg <= 1'b1;
                  state_reg <= ST_IDLE;
               end else if (wr_ok && adr_reg == `REG_WAKE &&
                            hwdata[`WAKE_CMD_BIT]) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

endmodule // exec_unit

//--- tb/exec_unit_asserts.sv
// Concurrent checks on the execution unit's bus and core pins
`timescale 1ns/10ps
module exec_unit_asserts (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   // Core pins
   input wire wake_pin,
   input wire osc_run,
   input wire [7:0] timing_cfg
);
   wire take = hsel & htrans[1] & hready;
   wire [3:0] opc = hwdata[11:8];
   reg instr_ph;
   // Marks the data phase of an instruction word write
   always @(posedge clk) begin
      if (rst)
         instr_ph <= 1'b0;
      else
         instr_ph <= take & hwrite & (haddr[7:0] == 8'h00);
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("error response");
   chk_read_wait: assert property (take && !hwrite |=>
      !hreadyout ##1 hreadyout) else $error("read wait wrong");
   chk_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   chk_data_hold: assert property (!$stable(hrdata) |->
      $past(hreadyout) == 1'b0) else $error("read data moved");
   chk_timing_cause: assert property (
      !$stable(timing_cfg) |-> $past(instr_ph, 2) &&
      $past(opc, 2) == 4'h6) else $error("timing moved");
   chk_sleep_cause: assert property (
      $fell(osc_run) |-> $past(instr_ph, 2) &&
      $past(opc, 2) == 4'h8) else $error("stray halt");
   chk_sleep_halt: assert property (
      instr_ph && opc == 4'h8 && osc_run |-> ##2 !osc_run)
      else $error("no halt");
   chk_halt_stays: assert property (
      (!osc_run && !wake_pin && !hsel) [*4] |=> !osc_run)
      else $error("left halt");
   // Main scenarios
   cover property (take && !hwrite);
   cover property ($fell(osc_run));
   cover property ($rose(osc_run));
endmodule // exec_unit_asserts

bind exec_unit exec_unit_asserts exec_unit_asserts_i (.clk, .rst,
   .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
   .hresp, .hrdata, .wake_pin, .osc_run, .timing_cfg);

//--- tb/tb.sv
// Self-checking bench for the execution unit
`timescale 1ns/10ps
module tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0;
   reg wake_pin = 1'b0;
   wire hready;
   wire hresp;
   wire [31:0] hrdata;
   wire osc_run;
   wire [7:0] timing_cfg;
   logic [31:0] rd;
   integer err_count = 0;
   integer check_count = 0;
   integer cyc = 0;

   exec_unit exec_unit_i (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp,
      .hrdata, .wake_pin, .osc_run, .timing_cfg);

   // Clock
   always #5 clk = ~clk;

   // Cuts a hung run short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         give_verdict;
      end
   end

   task give_verdict;
      if (err_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] s, input logic [31:0] e);
      check_count = check_count + 1;
      if (s !== e) begin
         err_count = err_count + 1;
         $display("MISMATCH %0t got %h want %h", $time, s, e);
      end
   endtask

   // One single bus transfer; read data lands in rd
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   // Issues one instruction and lets it finish
   task op(input logic [3:0] o, input logic [7:0] k);
      xfer(1'b1, 8'h00, {20'h0, o, k});
      repeat (2) @(posedge clk);
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rc(8'h08, 32'h6);
      rc(8'h0C, 32'hFF);
      op(4'h5, 8'hA5);
      rc(8'h04, 32'hA5);
      op(4'h5, 8'h00);
      op(4'h1, 8'h00);
      rc(8'h08, 32'h7);
      op(4'h1, 8'h5A);
      rc(8'h04, 32'h5A);
      rc(8'h08, 32'h6);
      op(4'h1, 8'h00);
      op(4'h5, 8'h00);
      op(4'h1, 8'h00);
      op(4'h5, 8'h3C);
      rc(8'h08, 32'h7);
      op(4'h3, 8'h1F);
      rc(8'hFC, 32'h3C);
      rc(8'h08, 32'h7);
      op(4'h5, 8'h41);
      op(4'h2, 8'h1F);
      rc(8'h04, 32'h7D);
      rc(8'h08, 32'h6);
      op(4'h5, 8'h02);
      op(4'h2, 8'h3F);
      rc(8'hFC, 32'h3E);
      rc(8'h04, 32'h02);
      op(4'h4, 8'h20);
      rc(8'h08, 32'h7);
      op(4'h4, 8'h1F);
      rc(8'h04, 32'h3E);
      rc(8'h08, 32'h6);
      op(4'h6, 8'h00);
      chk({24'h0, timing_cfg}, 32'h3E);
      rc(8'h08, 32'h6);
      xfer(1'b1, 8'h10, 32'h7FF);
      op(4'h0, 8'h00);
      rc(8'h10, 32'h0);
      rc(8'h04, 32'h3E);
      xfer(1'b1, 8'h14, 32'h5A5);
      op(4'h7, 8'hC3);
      rc(8'h04, 32'hC3);
      rc(8'h10, 32'h5A5);
      rc(8'h08, 32'h6);
      rc(8'h40, 32'h0);
      repeat (300) @(posedge clk);
      op(4'h8, 8'h00);
      chk({31'h0, osc_run}, 32'h0);
      rc(8'h18, 32'h0);
      rc(8'h08, 32'h12);
      op(4'h5, 8'h99);
      rc(8'h04, 32'hC3);
      repeat (8) @(posedge clk);
      wake_pin <= 1'b1;
      repeat (10) @(posedge clk);
      wake_pin <= 1'b0;
      chk({31'h0, osc_run}, 32'h1);
      rc(8'h08, 32'h0A);
      op(4'h8, 8'h00);
      rc(8'h08, 32'h1A);
      xfer(1'b1, 8'h1C, 32'h1);
      repeat (5) @(posedge clk);
      chk({31'h0, osc_run}, 32'h1);
      give_verdict;
   end
endmodule // tb
